// >>> hdl/epa_exception_arbiter.sv
/*
  Exception priority arbiter: pending/active flags, priority levels,
  boot vector fetch, entry with stacking, late arrival, tail-chaining
  and return. Assumes the core's stacking, unstacking and vector fetch
  paths answer with one-cycle acknowledge pulses on ref_clk.
*/
`timescale 1ns/100ps
`include "epa_defs.svh"

module epa_exception_arbiter #(
  parameter int NIRQ = 32,
  parameter int NUM_EXC = 16 + NIRQ,
  parameter int NW = $clog2(NUM_EXC)
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [NUM_EXC-1:0] exc_req,
  input wire logic prio_wr_en,
  input wire logic [NW-1:0] prio_wr_num,
  input wire logic [7:0] prio_wr_value,
  input wire logic primask,
  input wire logic exc_return,
  output logic vec_req,
  output logic [31:0] vec_addr,
  input wire logic vec_ack,
  input wire logic [31:0] vec_data,
  output logic stack_req,
  input wire logic stack_ack,
  output logic unstack_req,
  input wire logic unstack_done,
  output logic [31:0] initial_stack_value,
  output logic [31:0] handler_addr,
  output logic [NW-1:0] handler_num,
  output logic handler_start,
  output logic late_arrival,
  output logic tail_chain,
  output logic thread_mode,
  output logic [NUM_EXC-1:0] pending,
  output logic [NUM_EXC-1:0] active
);

  epa_pkg::epa_state_e state_q, state_d;
  logic [NUM_EXC-1:0] pending_q, pending_d;
  logic [NUM_EXC-1:0] active_q, active_d;
  logic [1:0] level_q [NUM_EXC];
  logic [1:0] level_d [NUM_EXC];
  logic [NW-1:0] entry_num_q, entry_num_d;
  logic [3:0] stk_cnt_q, stk_cnt_d;
  logic late_q, late_d;
  logic late_served_q, late_served_d;
  logic [31:0] vec_addr_q, vec_addr_d;
  logic [31:0] stk_init_q, stk_init_d;
  logic [31:0] hnd_addr_q, hnd_addr_d;
  logic [NW-1:0] hnd_num_q, hnd_num_d;
  logic hnd_start_q, hnd_start_d;
  logic late_pulse_q, late_pulse_d;
  logic tail_q, tail_d;

  logic [NUM_EXC*3-1:0] rank_flat;
  logic [NUM_EXC-1:0] eligible;
  logic win_valid;
  logic [NW-1:0] win_num;
  epa_pkg::epa_rank_t win_rank;
  logic cur_valid;
  logic [NW-1:0] cur_num;
  epa_pkg::epa_rank_t cur_rank_raw;
  epa_pkg::epa_rank_t cur_rank;
  epa_pkg::epa_rank_t entry_rank;

  // Fixed exceptions take negative-priority ranks above all levels
  function automatic epa_pkg::epa_rank_t rank_of(input int num, input logic [1:0] level);
    epa_pkg::epa_rank_t r;
    r = `EPA_RANK_CFG_BASE + {1'b0, level};
    if (num == `EPA_NUM_RESET)
      r = `EPA_RANK_RESET;
    else if (num == `EPA_NUM_NMI)
      r = `EPA_RANK_NMI;
    else if (num == `EPA_NUM_FAULT)
      r = `EPA_RANK_FAULT;
    return r;
  endfunction : rank_of

  // Only numbers other than the stack value and the fixed three accept a level
  function automatic logic is_configurable(input logic [NW-1:0] num);
    return (32'(num) != `EPA_NUM_RESET) && (32'(num) != `EPA_NUM_NMI) &&
      (32'(num) != `EPA_NUM_FAULT) && (32'(num) != `EPA_NUM_STACK_VALUE);
  endfunction : is_configurable

  // Vector address is the table base plus four bytes per number
  function automatic logic [31:0] vector_of(input logic [NW-1:0] num);
    return `EPA_VT_BASE + {{(30-NW){1'b0}}, num, 2'b00};
  endfunction : vector_of

  always_comb
  begin
    for (int i = 0; i < NUM_EXC; i++)
    begin
      rank_flat[i*3 +: 3] = rank_of(i, level_q[i]);
      // Mask holds off every configurable exception, leaves it pending
      eligible[i] = pending_q[i] && !(primask && rank_flat[i*3 +: 3] >= `EPA_RANK_CFG_BASE);
    end
  end

  epa_winner #(
    .NUM_EXC(NUM_EXC),
    .NW(NW)
  ) u_pend_win (
    .flags(eligible),
    .ranks(rank_flat),
    .win_valid(win_valid),
    .win_num(win_num),
    .win_rank(win_rank)
  );

  // Best active handler gives the current execution priority
  epa_winner #(
    .NUM_EXC(NUM_EXC),
    .NW(NW)
  ) u_act_win (
    .flags(active_q),
    .ranks(rank_flat),
    .win_valid(cur_valid),
    .win_num(cur_num),
    .win_rank(cur_rank_raw)
  );

  assign cur_rank = cur_valid ? cur_rank_raw : `EPA_RANK_THREAD;
  assign entry_rank = rank_flat[32'(entry_num_q)*3 +: 3];

  always_comb
  begin
    state_d = state_q;
    pending_d = pending_q;
    active_d = active_q;
    level_d = level_q;
    entry_num_d = entry_num_q;
    stk_cnt_d = stk_cnt_q;
    late_d = late_q;
    late_served_d = late_served_q;
    stk_init_d = stk_init_q;
    hnd_addr_d = hnd_addr_q;
    hnd_num_d = hnd_num_q;
    hnd_start_d = 1'b0;
    late_pulse_d = 1'b0;
    tail_d = 1'b0;

    if (prio_wr_en && is_configurable(prio_wr_num))
      level_d[prio_wr_num] = prio_wr_value[`EPA_LEVEL_MSB:`EPA_LEVEL_LSB];

    unique case (state_q)
      epa_pkg::ST_BOOT_STK:
      begin
        entry_num_d = NW'(`EPA_NUM_STACK_VALUE);
        if (vec_ack)
        begin
          stk_init_d = vec_data;
          entry_num_d = NW'(`EPA_NUM_RESET);
          state_d = epa_pkg::ST_BOOT_VEC;
        end
      end
      epa_pkg::ST_BOOT_VEC:
      begin
        if (vec_ack)
        begin
          hnd_addr_d = vec_data;
          hnd_num_d = NW'(`EPA_NUM_RESET);
          hnd_start_d = 1'b1;
          state_d = epa_pkg::ST_RUN;
        end
      end
      epa_pkg::ST_RUN:
      begin
        if (exc_return && cur_valid)
        begin
          // Retire the finishing handler, decide next cycle
          active_d[cur_num] = 1'b0;
          state_d = epa_pkg::ST_RETCHK;
        end
        else if (win_valid && win_rank < cur_rank)
        begin
          entry_num_d = win_num;
          stk_cnt_d = '0;
          late_d = 1'b0;
          state_d = epa_pkg::ST_STACK;
        end
      end
      epa_pkg::ST_STACK:
      begin
        // A more urgent arrival redirects the vector fetch only
        if (win_valid && win_rank < entry_rank)
        begin
          entry_num_d = win_num;
          late_d = 1'b1;
          late_pulse_d = 1'b1;
        end
        if (stack_ack)
        begin
          stk_cnt_d = stk_cnt_q + 4'h1;
          if (stk_cnt_q == `EPA_FRAME_WORDS - 4'h1)
            state_d = epa_pkg::ST_VFETCH;
        end
      end
      epa_pkg::ST_VFETCH:
      begin
        if (vec_ack)
        begin
          hnd_addr_d = vec_data;
          hnd_num_d = entry_num_q;
          hnd_start_d = 1'b1;
          pending_d[entry_num_q] = 1'b0;
          active_d[entry_num_q] = 1'b1;
          late_served_d = late_q;
          late_d = 1'b0;
          state_d = epa_pkg::ST_RUN;
        end
      end
      epa_pkg::ST_RETCHK:
      begin
        // Earlier exception of a late arrival is still pending here
        if (win_valid && win_rank < cur_rank)
        begin
          entry_num_d = win_num;
          tail_d = 1'b1;
          state_d = epa_pkg::ST_VFETCH;
        end
        else
        begin
          state_d = epa_pkg::ST_UNSTACK;
        end
        late_served_d = 1'b0;
      end
      epa_pkg::ST_UNSTACK:
      begin
        if (unstack_done)
        begin
          hnd_num_d = cur_num;
          state_d = epa_pkg::ST_RUN;
        end
      end
      default:
      begin
        state_d = epa_pkg::ST_RUN;
      end
    endcase

    // A request in the clearing cycle still leaves the flag set
    pending_d = pending_d | exc_req;
    pending_d[`EPA_NUM_STACK_VALUE] = 1'b0;
    vec_addr_d = vector_of(entry_num_d);
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= epa_pkg::ST_BOOT_STK;
      pending_q <= '0;
      active_q <= '0;
      for (int i = 0; i < NUM_EXC; i++)
        level_q[i] <= `EPA_LEVEL_RESET;
      entry_num_q <= '0;
      stk_cnt_q <= '0;
      late_q <= 1'b0;
      late_served_q <= 1'b0;
      vec_addr_q <= `EPA_VT_BASE;
      stk_init_q <= '0;
      hnd_addr_q <= '0;
      hnd_num_q <= '0;
      hnd_start_q <= 1'b0;
      late_pulse_q <= 1'b0;
      tail_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      pending_q <= pending_d;
      active_q <= active_d;
      level_q <= level_d;
      entry_num_q <= entry_num_d;
      stk_cnt_q <= stk_cnt_d;
      late_q <= late_d;
      late_served_q <= late_served_d;
      vec_addr_q <= vec_addr_d;
      stk_init_q <= stk_init_d;
      hnd_addr_q <= hnd_addr_d;
      hnd_num_q <= hnd_num_d;
      hnd_start_q <= hnd_start_d;
      late_pulse_q <= late_pulse_d;
      tail_q <= tail_d;
    end
  end

  assign vec_req = (state_q == epa_pkg::ST_BOOT_STK) || (state_q == epa_pkg::ST_BOOT_VEC) ||
    (state_q == epa_pkg::ST_VFETCH);
  assign stack_req = (state_q == epa_pkg::ST_STACK);
  assign unstack_req = (state_q == epa_pkg::ST_UNSTACK);
  assign vec_addr = vec_addr_q;
  assign initial_stack_value = stk_init_q;
  assign handler_addr = hnd_addr_q;
  assign handler_num = hnd_num_q;
  assign handler_start = hnd_start_q;
  assign late_arrival = late_pulse_q;
  assign tail_chain = tail_q;
  assign thread_mode = !cur_valid;
  assign pending = pending_q;
  assign active = active_q;

endmodule : epa_exception_arbiter

// >>> hdl/epa_winner.sv
/*
  Selects the most urgent exception among a set of flagged ones.
  Assumes ranks arrive flattened, three bits per exception number.
*/
`timescale 1ns/100ps
`include "epa_defs.svh"

module epa_winner #(
  parameter int NUM_EXC = 48,
  parameter int NW = 6
) (
  input wire logic [NUM_EXC-1:0] flags,
  input wire logic [NUM_EXC*3-1:0] ranks,
  output logic win_valid,
  output logic [NW-1:0] win_num,
  output epa_pkg::epa_rank_t win_rank
);

  always_comb
  begin
    win_valid = 1'b0;
    win_num = '0;
    win_rank = `EPA_RANK_THREAD;
    for (int i = 0; i < NUM_EXC; i++)
    begin
      // Strict compare keeps the lower number on a tie
      if (flags[i] && (!win_valid || ranks[i*3 +: 3] < win_rank))
      begin
        win_valid = 1'b1;
        win_num = NW'(i);
        win_rank = ranks[i*3 +: 3];
      end
    end
  end

endmodule : epa_winner

// >>> include/epa_defs.svh
/*
  Constants for the exception priority arbiter: vector table layout,
  fixed exception numbers, priority ranks and stack frame size.
  Assumes it is included by bare name after any package.
*/
// Behaviour
// - Vector table base fixed at address zero
// - Stack value, reset, NMI vectors at 0x00/04/08
// - Smaller priority value means more urgent
// - Only reset, fault, NMI priorities are fixed
// - Configurable priorities reset to zero
// - Four configurable levels, 0 to 192 step 64
// - Fixed negative priorities beat all configurable
// - Equal priority: lowest exception number first
// - Preempt handler only on strictly higher priority
// - Equal priority arrival only becomes pending
// - Normal return when nothing qualifies to chain
// - Normal return unstacks the saved context
// - Qualifying pending on completion: chain, no unstack
// - Higher arrival during stacking takes the vector fetch
// - Stacking continues unchanged on late arrival
// - After late handler, ordinary tail-chain decision
// - Take exception in thread mode or when outranking
// - Plain entry pushes eight-word frame
// - Late arrival keeps earlier pending status
`ifndef EPA_DEFS_SVH
`define EPA_DEFS_SVH

`define EPA_VT_BASE 32'h0000_0000
`define EPA_NUM_STACK_VALUE 32'h0000_0000
`define EPA_NUM_RESET 32'h0000_0001
`define EPA_NUM_NMI 32'h0000_0002
`define EPA_NUM_FAULT 32'h0000_0003
`define EPA_NUM_FIRST_IRQ 32'h0000_0010
`define EPA_RANK_RESET 3'h0
`define EPA_RANK_NMI 3'h1
`define EPA_RANK_FAULT 3'h2
`define EPA_RANK_CFG_BASE 3'h3
`define EPA_RANK_THREAD 3'h7
`define EPA_LEVEL_RESET 2'h0
`define EPA_LEVEL_MSB 7
`define EPA_LEVEL_LSB 6
`define EPA_FRAME_WORDS 4'h8

`endif

// >>> include/epa_pkg.sv
/*
  Types shared by the exception priority arbiter modules.
  Assumes nothing of its surroundings.
*/
package epa_pkg;

  typedef logic [2:0] epa_rank_t;

  typedef enum logic [2:0] {
    ST_BOOT_STK = 3'b000,
    ST_BOOT_VEC = 3'b001,
    ST_RUN = 3'b010,
    ST_STACK = 3'b011,
    ST_VFETCH = 3'b100,
    ST_RETCHK = 3'b101,
    ST_UNSTACK = 3'b110
  } epa_state_e;

endpackage : epa_pkg

// >>> tb/epa_core_model.sv
/* Core model: answers vector, stacking and unstacking requests.
   Assumes requests hold until answered; slow answers one cycle in four. */
`timescale 1ns/100ps

module epa_core_model (
  input wire logic ref_clk,
  input wire logic slow,
  input wire logic vec_req,
  input wire logic [31:0] vec_addr,
  output logic vec_ack = 1'b0,
  output logic [31:0] vec_data = 32'h0,
  input wire logic stack_req,
  output logic stack_ack = 1'b0,
  input wire logic unstack_req,
  output logic unstack_done = 1'b0
);
  logic [1:0] cyc = 2'h0;
  logic go;

  always @(negedge ref_clk)
  begin
    cyc = cyc + 2'h1;
    go = !slow || cyc == 2'h3;
    vec_ack = vec_req && go;
    stack_ack = stack_req && go;
    unstack_done = unstack_req && go;
    // Word is junk unless acknowledged
    if (vec_ack)
      vec_data = vec_addr == 32'h0 ? 32'h2000_0ff0 : 32'h0000_1000 | vec_addr;
    else
      vec_data = ~vec_data ^ {30'h0, cyc};
  end
endmodule : epa_core_model

// >>> tb/epa_properties.sv
/* Port checker for the exception arbiter.
   Bound to epa_exception_arbiter; sees only its ports. */
`timescale 1ns/100ps

module epa_properties #(
  parameter int NUM_EXC = 48,
  parameter int NW = 6
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [NUM_EXC-1:0] exc_req,
  input wire logic exc_return,
  input wire logic vec_req,
  input wire logic [31:0] vec_addr,
  input wire logic vec_ack,
  input wire logic [31:0] vec_data,
  input wire logic stack_req,
  input wire logic stack_ack,
  input wire logic unstack_req,
  input wire logic unstack_done,
  input wire logic [31:0] initial_stack_value,
  input wire logic [31:0] handler_addr,
  input wire logic [NW-1:0] handler_num,
  input wire logic handler_start,
  input wire logic late_arrival,
  input wire logic tail_chain,
  input wire logic thread_mode,
  input wire logic [NUM_EXC-1:0] pending,
  input wire logic [NUM_EXC-1:0] active
);
  logic [3:0] words_q;
  logic [3:0] words_d;

  // Frame words pushed so far
  always_comb
  begin
    words_d = stack_req ? words_q + 4'(stack_ack) : 4'h0;
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      words_q <= 4'h0;
    else
      words_q <= words_d;
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  a_boot_second_word: assert property (
    vec_req && vec_ack && vec_addr == 32'h0 |=> vec_req && vec_addr == 32'h4
    && initial_stack_value == $past(vec_data)) else $error("boot fetch order wrong");
  a_vector_starts_handler: assert property (
    vec_req && vec_ack && vec_addr != 32'h0 |=> handler_start && handler_addr == $past(vec_data))
    else $error("handler not started from vector");
  a_start_vector_addr: assert property (
    handler_start |-> $past(vec_addr) == {handler_num, 2'h0}) else $error("vector address wrong");
  a_frame_eight_words: assert property (
    stack_req && stack_ack && words_q == 4'h7 |=> !stack_req && vec_req)
    else $error("frame not closed after eight words");
  a_frame_keeps_going: assert property (
    stack_req && words_q != 4'h7 |=> stack_req) else $error("stacking cut short");
  a_request_sets_pending: assert property (
    |exc_req[NUM_EXC-1:1] |=> ((pending | NUM_EXC'(1)) & $past(exc_req)) == $past(exc_req))
    else $error("request not pending");
  a_return_path: assert property (
    exc_return && !thread_mode && !vec_req && !stack_req && !unstack_req
    |=> ##1 (unstack_req != (tail_chain && vec_req))) else $error("return path wrong");
  a_thread_flag: assert property (
    thread_mode == (active == '0)) else $error("thread flag wrong");

  c_tail: cover property (tail_chain);
  c_late: cover property (late_arrival);
  c_nested_return: cover property (unstack_req && unstack_done && !thread_mode);
endmodule : epa_properties

// >>> tb/exception_priority_arbiter_test.sv
/* Self-checking bench for epa_exception_arbiter with a core model.
   Assumes package, header, model and checker are compiled first. */
`timescale 1ns/100ps

module exception_priority_arbiter_test;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [47:0] exc_req = '0;
  logic prio_wr_en = 1'b0;
  logic [5:0] prio_wr_num = '0;
  logic [7:0] prio_wr_value = '0;
  logic primask = 1'b0;
  logic exc_return = 1'b0;
  logic slow = 1'b0;
  logic tc_seen = 1'b0;
  logic la_seen = 1'b0;
  logic [15:0] rnd = 16'hd88d;
  logic vec_req, vec_ack, stack_req, stack_ack, unstack_req, unstack_done;
  logic handler_start, late_arrival, tail_chain, thread_mode;
  logic [31:0] vec_addr, vec_data, initial_stack_value, handler_addr;
  logic [5:0] handler_num;
  logic [47:0] pending, active;
  int n_fail = 0;
  int checks_done = 0;
  int cycles = 0;

  epa_exception_arbiter u_dut (.ref_clk, .resetn, .exc_req, .prio_wr_en, .prio_wr_num,
    .prio_wr_value, .primask, .exc_return, .vec_req, .vec_addr, .vec_ack, .vec_data,
    .stack_req, .stack_ack, .unstack_req, .unstack_done, .initial_stack_value,
    .handler_addr, .handler_num, .handler_start, .late_arrival, .tail_chain,
    .thread_mode, .pending, .active);
  epa_core_model u_core (.ref_clk, .slow, .vec_req, .vec_addr, .vec_ack, .vec_data,
    .stack_req, .stack_ack, .unstack_req, .unstack_done);

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude

  task automatic setp(input int n, input logic [1:0] lv);
    prio_wr_en = 1'b1;
    prio_wr_num = 6'(n);
    prio_wr_value = {lv, rnd[5:0]};
    @(negedge ref_clk);
    prio_wr_en = 1'b0;
    // Idle cycle so back-to-back writes always drop the strobe low for one full cycle
    @(negedge ref_clk);
  endtask : setp

  task automatic pulse(input logic [47:0] m);
    exc_req = m;
    @(negedge ref_clk);
    exc_req = '0;
  endtask : pulse

  task automatic wait_start(input int n);
    int i;
    @(negedge ref_clk);
    for (i = 0; i < 400 && handler_start !== 1'b1; i++)
      @(negedge ref_clk);
    chk({handler_start, handler_num}, {1'b1, 6'(n)});
    chk(handler_addr, 32'h0000_1000 | (n << 2));
  endtask : wait_start

  task automatic ret_to(input int n);
    int i;
    exc_return = 1'b1;
    @(negedge ref_clk);
    exc_return = 1'b0;
    repeat (2) @(negedge ref_clk);
    for (i = 0; i < 100 && unstack_req === 1'b1; i++)
      @(negedge ref_clk);
    chk({thread_mode, unstack_req, handler_num}, {n == 0, 1'b0, 6'(n)});
  endtask : ret_to

  task automatic run_pair(input int a, input int b, input logic [1:0] la, input logic [1:0] lb);
    int f;
    f = (la < lb || (la == lb && a < b)) ? a : b;
    tc_seen = 1'b0;
    pulse((48'h1 << a) | (48'h1 << b));
    wait_start(f);
    chk(pending[a + b - f], 1'b1);
    exc_return = 1'b1;
    @(negedge ref_clk);
    exc_return = 1'b0;
    wait_start(a + b - f);
    chk(tc_seen, 1'b1);
    ret_to(0);
  endtask : run_pair

  initial
  begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  always @(negedge ref_clk)
  begin
    cycles++;
    tc_seen = tc_seen | (tail_chain === 1'b1);
    la_seen = la_seen | (late_arrival === 1'b1);
    if (cycles > 20000)
    begin
      n_fail++;
      conclude();
    end
  end

  initial
  begin
    int k;
    int a;
    int b;
    repeat (12) @(negedge ref_clk);
    resetn = 1'b1;
    wait_start(1);
    chk({thread_mode, initial_stack_value}, {1'b1, 32'h2000_0ff0});
    run_pair(17, 16, 2'h0, 2'h0);
    setp(20, 2'h2);
    setp(21, 2'h2);
    pulse(48'h1 << 20);
    wait_start(20);
    pulse(48'h1 << 21);
    repeat (20) @(negedge ref_clk);
    chk({stack_req, pending[21], handler_num}, {2'b01, 6'h14});
    setp(2, 2'h3);
    pulse(48'h1 << 2);
    wait_start(2);
    chk({active[20], active[2]}, 2'b11);
    ret_to(20);
    exc_return = 1'b1;
    @(negedge ref_clk);
    exc_return = 1'b0;
    wait_start(21);
    ret_to(0);
    setp(22, 2'h3);
    setp(23, 2'h1);
    pulse(48'h1 << 22);
    repeat (3) @(negedge ref_clk);
    pulse(48'h1 << 23);
    wait_start(23);
    chk({pending[22], la_seen}, 2'b11);
    exc_return = 1'b1;
    @(negedge ref_clk);
    exc_return = 1'b0;
    wait_start(22);
    ret_to(0);
    primask = 1'b1;
    pulse(48'h1 << 24);
    repeat (10) @(negedge ref_clk);
    chk({stack_req, pending[24]}, 2'b01);
    primask = 1'b0;
    wait_start(24);
    ret_to(0);
    for (k = 0; k < 12; k++)
    begin
      rnd = lfsr(rnd);
      slow = rnd[15];
      a = 16 + rnd[4:0];
      b = 16 + (rnd[4:0] + 1 + rnd[8:5]) % 32;
      setp(a, rnd[10:9]);
      setp(b, rnd[12:11]);
      run_pair(a, b, rnd[10:9], rnd[12:11]);
    end
    conclude();
  end
endmodule : exception_priority_arbiter_test

bind epa_exception_arbiter epa_properties #(.NUM_EXC(NUM_EXC), .NW(NW)) u_props (.ref_clk,
  .resetn, .exc_req, .exc_return, .vec_req, .vec_addr, .vec_ack, .vec_data, .stack_req,
  .stack_ack, .unstack_req, .unstack_done, .initial_stack_value, .handler_addr,
  .handler_num, .handler_start, .late_arrival, .tail_chain, .thread_mode, .pending,
  .active);
